// File: hw/dcg_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the register bank
// Assumes: word index addressing, byte address is four times the index
// Notes: offsets marked as added have no printed address
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH
// ==========================================================================
// register indices
`define DCG_IDX_PRIMARY_CONTROL 8'h01
`define DCG_IDX_DEVICE_FLAGS 8'h03
`define DCG_IDX_OUTPUT_LAYOUT 8'h04
`define DCG_IDX_EXPOSURE 8'h05
`define DCG_IDX_HW_IDENTITY 8'h06
`define DCG_IDX_BOARD_REV 8'h07
`define DCG_IDX_SW_REV 8'h08
`define DCG_IDX_ILLUM_FREQ 8'h09
`define DCG_IDX_ACQ_RATE 8'h0A
`define DCG_IDX_OPTICS 8'h0B
`define DCG_IDX_SERIAL_LOW 8'h0C
`define DCG_IDX_SERIAL_HIGH 8'h0D
`define DCG_IDX_TALLY 8'h0E
`define DCG_IDX_VALID_LOWER 8'h0F
`define DCG_IDX_VALID_UPPER 8'h10
`define DCG_IDX_SECONDARY 8'h19
`define DCG_IDX_PROC_DUR 8'h1A
`define DCG_IDX_EMIT_TEMP 8'h1B
`define DCG_IDX_BASE_TEMP 8'h1C
`define DCG_IDX_LIN_AMP 8'h1D
`define DCG_IDX_LIN_PHASE 8'h1E
`define DCG_IDX_UNLOCK_KEY 8'h22
`define DCG_IDX_EMIT_LIMIT 8'h24
`define DCG_IDX_HFOV 8'h26
`define DCG_IDX_VFOV 8'h27
`define DCG_IDX_POSTPONE 8'h2B
`define DCG_IDX_BOOT_INFO 8'h2C
`define DCG_IDX_THERM_SLOPE 8'h2D
// ==========================================================================
// field positions
`define DCG_PC_VIDEO 0
`define DCG_PC_TRIGGER 4
`define DCG_PC_CLEAR 6
`define DCG_PC_BOOT 8
`define DCG_FL_BOOT 0
`define DCG_FL_READY 1
`define DCG_FL_CALIB 2
`define DCG_FL_EMIT_ERR 3
`define DCG_FL_BASE_ERR 4
`define DCG_FL_CAL_MISS 5
`define DCG_FL_FACTORY 6
`define DCG_FL_FAULTY 12
`define DCG_FMT_LSB 3
`define DCG_FMT_MSB 6
`define DCG_SC_AUTO_EXP 3
`define DCG_SC_EXTREMES 7
`define DCG_SC_LED_OFF 8
`define DCG_SC_MEDIAN 11
`define DCG_BOOT_CNT_LSB 13
// ==========================================================================
// reset values and limits
`define DCG_RST_PRIMARY 16'h0001
`define DCG_RST_LAYOUT 16'h0000
`define DCG_RST_EXPOSURE 16'h05DC
`define DCG_RST_ILLUM_FREQ 16'h4E20
`define DCG_RST_ACQ_RATE 16'h0028
`define DCG_RST_OPTICS 16'h005A
`define DCG_RST_VALID_LOWER 16'h0064
`define DCG_RST_VALID_UPPER 16'h3A98
`define DCG_RST_SECONDARY 16'h0800
`define DCG_RST_LIN_AMP 16'h01AF
`define DCG_RST_LIN_PHASE 16'h1B58
`define DCG_RST_UNLOCK_KEY 16'h0000
`define DCG_RST_EMIT_LIMIT 16'h2328
`define DCG_RST_POSTPONE 16'h0000
`define DCG_RST_THERM_SLOPE 16'h1004
`define DCG_EXPOSURE_MIN 16'h0032
`define DCG_EXPOSURE_MAX 16'h61A8
`define DCG_UNLOCK_VALUE 16'h4877
`define DCG_TEMP_ABSENT 16'hFFFF
`define DCG_MASK_PRIMARY 16'h0001
`define DCG_MASK_LAYOUT 16'h0078
`define DCG_MASK_OPTICS 16'h00FF
`define DCG_MASK_SECONDARY 16'h0988
// ==========================================================================
// timing: postpone counts in microseconds, processing time in 100 us units
`define DCG_CLK_MHZ 50
`define DCG_US_CYCLES (`DCG_CLK_MHZ)
`define DCG_TICK_US 100
`endif

// File: hw/dcg_pkg.sv
// Purpose: types shared by the register bank
// Assumes: constants come from dcg_consts.svh
// Notes: none
`default_nettype none
package dcg_pkg;
  typedef struct packed {
    logic video_mode;
    logic auto_exposure;
    logic segment_extremes;
    logic status_led_off;
    logic median_min;
    logic [3:0] layout;
    logic [7:0] lens_angle;
  } dcg_ctrl_s;
  typedef struct packed {
    logic calibrating;
    logic emit_sensor_err;
    logic base_sensor_err;
    logic calib_missing;
    logic factory_loaded;
    logic [15:0] emit_temp;
    logic [15:0] base_temp;
  } dcg_sense_s;
  typedef enum logic [1:0] {DCG_IDLE, DCG_WAIT, DCG_BUSY} dcg_cap_e;
endpackage
`default_nettype wire

// File: hw/dcg_regs.sv
// Purpose: general control and status register bank of a depth camera, Avalon-MM slave
// Assumes: 50 MHz clock, 16-bit registers in the low half of 32-bit words
// Notes: capture engine sits outside; this bank sequences trigger, delay and tallies
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "dcg_consts.svh"
`default_nettype none
module dcg_regs #(
  parameter logic [15:0] HW_IDENTITY = 16'h1234, // arbitrary value
  parameter logic [15:0] BOARD_REV = 16'h0011,
  parameter logic [15:0] SW_REV = 16'h0841,
  parameter logic [31:0] SERIAL = 32'h0000_0001,
  parameter logic [15:0] HFOV = 16'h2328,
  parameter logic [15:0] VFOV = 16'h1770
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // capture engine
  input wire logic hw_trigger_i,
  input wire logic frame_done_i,
  input wire logic frame_faulty_i,
  input wire logic [15:0] pixel_amplitude_i,
  output logic capture_start_o,
  output logic pixel_valid_o,
  output dcg_pkg::dcg_ctrl_s ctrl_o,
  output logic [15:0] exposure_o,
  // sensors and firmware status
  input wire dcg_pkg::dcg_sense_s sense_i,
  input wire logic boot_trial_i,
  input wire logic firmware_alive_i,
  input wire logic bootloader_active_i,
  output logic boot_request_o,
  // command port
  output logic command_unlocked_o
);
  import dcg_pkg::*;

  // ==========================================================================
  // bus handshake: one wait cycle, answer on the second edge
  logic ack;
  logic req;
  logic wr_hit;
  logic [15:0] wdata;
  assign req = (avs_read_i | avs_write_i) & ~ack;
  assign wr_hit = avs_write_i & ~ack;
  assign wdata = avs_writedata_i[15:0];

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= req;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~req;
  end

  // low byte lanes carry the 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic wr_at(input logic [7:0] idx);
    wr_at = wr_hit && (avs_address_i == idx);
  endfunction

  // ==========================================================================
  // writable registers
  logic [15:0] primary_control, output_layout_select, exposure_duration;
  logic [15:0] illumination_frequency, acquisition_rate, optics_setup;
  logic [15:0] validity_amplitude_lower, validity_amplitude_upper, secondary_control;
  logic [15:0] linearization_amplitude, linearization_phase, command_unlock_key;
  logic [15:0] emitter_temperature_limit, capture_postpone, thermal_correction_slope;
  logic [15:0] next_exposure;

  always_comb
  begin
    next_exposure = merge(exposure_duration, wdata, avs_byteenable_i[1:0]);
    if (next_exposure < `DCG_EXPOSURE_MIN)
      next_exposure = `DCG_EXPOSURE_MIN;
    else if (next_exposure > `DCG_EXPOSURE_MAX)
      next_exposure = `DCG_EXPOSURE_MAX;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      primary_control <= `DCG_RST_PRIMARY;
      output_layout_select <= `DCG_RST_LAYOUT;
      exposure_duration <= `DCG_RST_EXPOSURE;
      illumination_frequency <= `DCG_RST_ILLUM_FREQ;
      acquisition_rate <= `DCG_RST_ACQ_RATE;
      optics_setup <= `DCG_RST_OPTICS;
      validity_amplitude_lower <= `DCG_RST_VALID_LOWER;
      validity_amplitude_upper <= `DCG_RST_VALID_UPPER;
      secondary_control <= `DCG_RST_SECONDARY;
      linearization_amplitude <= `DCG_RST_LIN_AMP;
      linearization_phase <= `DCG_RST_LIN_PHASE;
      command_unlock_key <= `DCG_RST_UNLOCK_KEY;
      emitter_temperature_limit <= `DCG_RST_EMIT_LIMIT;
      capture_postpone <= `DCG_RST_POSTPONE;
      thermal_correction_slope <= `DCG_RST_THERM_SLOPE;
    end
    else
    begin
      // reserved bits masked, action bits self-clear
      if (wr_at(`DCG_IDX_PRIMARY_CONTROL))
        primary_control <= merge(primary_control, wdata, avs_byteenable_i[1:0])
                           & `DCG_MASK_PRIMARY;
      if (wr_at(`DCG_IDX_OUTPUT_LAYOUT))
        output_layout_select <= merge(output_layout_select, wdata, avs_byteenable_i[1:0])
                                & `DCG_MASK_LAYOUT;
      if (wr_at(`DCG_IDX_EXPOSURE))
        exposure_duration <= next_exposure;
      if (wr_at(`DCG_IDX_ILLUM_FREQ))
        illumination_frequency <= merge(illumination_frequency, wdata, avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_ACQ_RATE))
        acquisition_rate <= merge(acquisition_rate, wdata, avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_OPTICS))
        optics_setup <= merge(optics_setup, wdata, avs_byteenable_i[1:0]) & `DCG_MASK_OPTICS;
      if (wr_at(`DCG_IDX_VALID_LOWER))
        validity_amplitude_lower <= merge(validity_amplitude_lower, wdata,
                                          avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_VALID_UPPER))
        validity_amplitude_upper <= merge(validity_amplitude_upper, wdata,
                                          avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_SECONDARY))
        secondary_control <= merge(secondary_control, wdata, avs_byteenable_i[1:0])
                             & `DCG_MASK_SECONDARY;
      if (wr_at(`DCG_IDX_LIN_AMP))
        linearization_amplitude <= merge(linearization_amplitude, wdata,
                                         avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_LIN_PHASE))
        linearization_phase <= merge(linearization_phase, wdata, avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_UNLOCK_KEY))
        command_unlock_key <= merge(command_unlock_key, wdata, avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_EMIT_LIMIT))
        emitter_temperature_limit <= merge(emitter_temperature_limit, wdata,
                                           avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_POSTPONE))
        capture_postpone <= merge(capture_postpone, wdata, avs_byteenable_i[1:0]);
      if (wr_at(`DCG_IDX_THERM_SLOPE))
        thermal_correction_slope <= merge(thermal_correction_slope, wdata,
                                          avs_byteenable_i[1:0]);
    end
  end

  // action strobes from a primary control write
  logic pc_wr;
  // plain operands: a function reading module signals would not wake the assign
  assign pc_wr = wr_hit & (avs_address_i == `DCG_IDX_PRIMARY_CONTROL) & avs_byteenable_i[0];
  logic sw_trigger, clear_flags;
  // trigger honoured only in manual mode
  assign sw_trigger = pc_wr & wdata[`DCG_PC_TRIGGER] & ~primary_control[`DCG_PC_VIDEO];
  assign clear_flags = pc_wr & wdata[`DCG_PC_CLEAR];

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      boot_request_o <= 1'b0;
    else
      boot_request_o <= wr_at(`DCG_IDX_PRIMARY_CONTROL) & avs_byteenable_i[1]
                        & wdata[`DCG_PC_BOOT];
  end

  // ==========================================================================
  // pin inputs: three stages, change accepted when stages two and three agree
  logic [2:0] trig_sync;
  logic trig_level, trig_prev;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_sync <= 3'h0;
      trig_level <= 1'b0;
      trig_prev <= 1'b0;
    end
    else
    begin
      trig_sync <= {trig_sync[1:0], hw_trigger_i};
      if (trig_sync[1] == trig_sync[2])
        trig_level <= trig_sync[2];
      trig_prev <= trig_level;
    end
  end

  // ==========================================================================
  // capture sequencing with postpone in microseconds
  dcg_cap_e cap_state;
  logic [5:0] us_div;
  logic [15:0] delay_cnt;
  logic trig_any;
  logic video_kick;
  assign trig_any = sw_trigger | (trig_level & ~trig_prev);
  assign video_kick = primary_control[`DCG_PC_VIDEO];

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cap_state <= DCG_IDLE;
      us_div <= 6'h00;
      delay_cnt <= 16'h0000;
      capture_start_o <= 1'b0;
    end
    else
    begin
      capture_start_o <= 1'b0;
      case (cap_state)
        DCG_IDLE:
          if (trig_any | video_kick)
          begin
            delay_cnt <= capture_postpone;
            us_div <= 6'h00;
            cap_state <= DCG_WAIT;
          end
        DCG_WAIT:
          if (delay_cnt == 16'h0000)
          begin
            capture_start_o <= 1'b1;
            cap_state <= DCG_BUSY;
          end
          else if (us_div == 6'(`DCG_US_CYCLES - 1))
          begin
            us_div <= 6'h00;
            delay_cnt <= delay_cnt - 16'h0001;
          end
          else
            us_div <= us_div + 6'h01;
        DCG_BUSY:
          if (frame_done_i)
            cap_state <= DCG_IDLE;
        default:
          cap_state <= DCG_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // frame tally and processing time
  logic [15:0] captured_image_tally, processing_duration, proc_cnt;
  logic [12:0] tick_div;
  // count frames, time processing in 100 us ticks
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      captured_image_tally <= 16'h0000;
      processing_duration <= 16'h0000;
      proc_cnt <= 16'h0000;
      tick_div <= 13'h0000;
    end
    else if (capture_start_o)
    begin
      proc_cnt <= 16'h0000;
      tick_div <= 13'h0000;
    end
    else if (cap_state == DCG_BUSY)
    begin
      if (frame_done_i)
      begin
        captured_image_tally <= captured_image_tally + 16'h0001;
        processing_duration <= proc_cnt;
      end
      else if (tick_div == 13'(`DCG_US_CYCLES * `DCG_TICK_US - 1))
      begin
        tick_div <= 13'h0000;
        proc_cnt <= proc_cnt + 16'h0001;
      end
      else
        tick_div <= tick_div + 13'h0001;
    end
  end

  // ==========================================================================
  // status flags: sticky frame flags, set wins over clear
  logic frame_ready, frame_faulty;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_ready <= 1'b0;
      frame_faulty <= 1'b0;
    end
    else
    begin
      if (frame_done_i & cap_state == DCG_BUSY)
        frame_ready <= 1'b1;
      else if (clear_flags)
        frame_ready <= 1'b0;
      if (frame_done_i & frame_faulty_i & cap_state == DCG_BUSY)
        frame_faulty <= 1'b1;
      else if (clear_flags)
        frame_faulty <= 1'b0;
    end
  end

  logic [15:0] device_flags;
  always_comb
  begin
    device_flags = 16'h0000;
    device_flags[`DCG_FL_BOOT] = bootloader_active_i;
    device_flags[`DCG_FL_READY] = frame_ready;
    device_flags[`DCG_FL_CALIB] = sense_i.calibrating;
    device_flags[`DCG_FL_EMIT_ERR] = sense_i.emit_sensor_err;
    device_flags[`DCG_FL_BASE_ERR] = sense_i.base_sensor_err;
    device_flags[`DCG_FL_CAL_MISS] = sense_i.calib_missing;
    device_flags[`DCG_FL_FACTORY] = sense_i.factory_loaded;
    device_flags[`DCG_FL_FAULTY] = frame_faulty;
  end

  // boot attempt counter, saturating, cleared by firmware
  logic [2:0] boot_cnt;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      boot_cnt <= 3'h0;
    else if (boot_trial_i & boot_cnt != 3'h7)
      boot_cnt <= boot_cnt + 3'h1;
    else if (firmware_alive_i)
      boot_cnt <= 3'h0;
  end

  logic [15:0] emit_temp, base_temp;
  assign emit_temp = sense_i.emit_sensor_err ? `DCG_TEMP_ABSENT : sense_i.emit_temp;
  assign base_temp = sense_i.base_sensor_err ? `DCG_TEMP_ABSENT : sense_i.base_temp;

  // ==========================================================================
  // read mux; unmapped reads zero with a decode error response
  logic [15:0] rd;
  logic hit;
  always_comb
  begin
    hit = 1'b1;
    case (avs_address_i)
      `DCG_IDX_PRIMARY_CONTROL: rd = primary_control;
      `DCG_IDX_DEVICE_FLAGS: rd = device_flags;
      `DCG_IDX_OUTPUT_LAYOUT: rd = output_layout_select;
      `DCG_IDX_EXPOSURE: rd = exposure_duration;
      `DCG_IDX_HW_IDENTITY: rd = HW_IDENTITY;
      `DCG_IDX_BOARD_REV: rd = BOARD_REV;
      `DCG_IDX_SW_REV: rd = SW_REV;
      `DCG_IDX_ILLUM_FREQ: rd = illumination_frequency;
      `DCG_IDX_ACQ_RATE: rd = acquisition_rate;
      `DCG_IDX_OPTICS: rd = optics_setup;
      `DCG_IDX_SERIAL_LOW: rd = SERIAL[15:0];
      `DCG_IDX_SERIAL_HIGH: rd = SERIAL[31:16];
      `DCG_IDX_TALLY: rd = captured_image_tally;
      `DCG_IDX_VALID_LOWER: rd = validity_amplitude_lower;
      `DCG_IDX_VALID_UPPER: rd = validity_amplitude_upper;
      `DCG_IDX_SECONDARY: rd = secondary_control;
      `DCG_IDX_PROC_DUR: rd = processing_duration;
      `DCG_IDX_EMIT_TEMP: rd = emit_temp;
      `DCG_IDX_BASE_TEMP: rd = base_temp;
      `DCG_IDX_LIN_AMP: rd = linearization_amplitude;
      `DCG_IDX_LIN_PHASE: rd = linearization_phase;
      `DCG_IDX_UNLOCK_KEY: rd = command_unlock_key;
      `DCG_IDX_EMIT_LIMIT: rd = emitter_temperature_limit;
      `DCG_IDX_HFOV: rd = HFOV;
      `DCG_IDX_VFOV: rd = VFOV;
      `DCG_IDX_POSTPONE: rd = capture_postpone;
      `DCG_IDX_BOOT_INFO: rd = {boot_cnt, 13'h0000};
      `DCG_IDX_THERM_SLOPE: rd = thermal_correction_slope;
      default:
      begin
        rd = 16'h0000;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end
    else if (req)
    begin
      avs_readdata_o <= avs_read_i ? {16'h0000, rd} : 32'h0000_0000;
      avs_response_o <= hit ? 2'h0 : 2'h3;
    end
  end

  // ==========================================================================
  // registered outputs to the capture engine and the command port
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_o <= '0;
      exposure_o <= `DCG_RST_EXPOSURE;
      pixel_valid_o <= 1'b0;
      command_unlocked_o <= 1'b0;
    end
    else
    begin
      ctrl_o.video_mode <= primary_control[`DCG_PC_VIDEO];
      ctrl_o.auto_exposure <= secondary_control[`DCG_SC_AUTO_EXP];
      ctrl_o.segment_extremes <= secondary_control[`DCG_SC_EXTREMES];
      ctrl_o.status_led_off <= secondary_control[`DCG_SC_LED_OFF];
      ctrl_o.median_min <= secondary_control[`DCG_SC_MEDIAN];
      ctrl_o.layout <= output_layout_select[`DCG_FMT_MSB:`DCG_FMT_LSB];
      ctrl_o.lens_angle <= optics_setup[7:0];
      exposure_o <= exposure_duration;
      pixel_valid_o <= pixel_amplitude_i >= validity_amplitude_upper;
      // key match unlocks the command port
      command_unlocked_o <= command_unlock_key == `DCG_UNLOCK_VALUE;
    end
  end
endmodule
`default_nettype wire

// File: dv/dcg_regs_checker.sv
// Purpose: port-level checks for the general register bank
// Assumes: sees only the ports of dcg_regs
// Notes: bound to every dcg_regs instance at the foot
`default_nettype none
module dcg_regs_checker (
  // watched ports
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic capture_start_o,
  input wire logic [15:0] exposure_o,
  input wire dcg_pkg::dcg_sense_s sense_i,
  input wire logic boot_request_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcg_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire ack = !avs_waitrequest_o;
  wire req = avs_read_i || avs_write_i;
  // ====================
  // assertions
  a_exp_range: assert property (exposure_o >= 16'h0032 && exposure_o <= 16'h61A8)
    else $error("exposure outside limits");
  a_ack_single: assert property (ack |=> !ack)
    else $error("waitrequest low too long");
  a_ack_bound: assert property (req && !ack |-> ##[1:2] ack)
    else $error("no answer to request");
  a_unmapped_resp: assert property (ack && avs_read_i && avs_address_i == 8'h02 |->
    avs_response_o == 2'h3 && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (ack && avs_read_i |-> avs_readdata_o[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_temp_absent: assert property (ack && avs_read_i && avs_address_i == 8'h1B &&
    sense_i.emit_sensor_err |-> avs_readdata_o[15:0] == 16'hFFFF)
    else $error("missing sensor not flagged");
  a_start_pulse: assert property (capture_start_o |=> !capture_start_o)
    else $error("capture start longer than a cycle");
  a_boot_cause: assert property (boot_request_o |->
    $past(avs_write_i && avs_writedata_i[8] && avs_address_i == 8'h01))
    else $error("boot request without write");
  a_data_hold: assert property (!req |=> $stable(avs_readdata_o))
    else $error("read data moved while idle");
  c_capture: cover property (capture_start_o);
  c_boot: cover property (boot_request_o);
  c_refused: cover property (ack && avs_response_o == 2'h3);
endmodule
bind dcg_regs dcg_regs_checker chk_u (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
  .capture_start_o, .exposure_o, .sense_i, .boot_request_o);
`default_nettype wire

// File: dv/dcg_regs_tb.sv
// Purpose: self-checking bench for the general register bank
// Assumes: 50 MHz clock, frame tally starts at zero
// Notes: byte enables drive the two low lanes, one write uses lane 0 alone
`default_nettype none
module dcg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcg_pkg::*;
  // ====================
  // signals and model
  logic clk_sys_i = 0, rst_i = 1, rd = 0, wr = 0, trg = 0, bad = 0, bla = 0, sb = 0;
  logic wt, cap, pv, brq, unl;
  logic [2:0] pl = 0;
  logic [3:0] be = 4'h3;
  logic [7:0] adr = 0;
  logic [15:0] amp = 0, expo, v;
  logic [31:0] wd = 0, q, rq;
  logic [1:0] resp, rr;
  dcg_sense_s sense = '0;
  dcg_ctrl_s ctrl;
  int errors = 0, checked = 0, n;
  int m [int];
  int rv [15] = '{32'h10001, 32'h40000, 32'h505DC, 32'h94E20, 32'hA0028, 32'hB005A,
    32'hF0064, 32'h103A98, 32'h190800, 32'h1D01AF, 32'h1E1B58, 32'h220000, 32'h242328,
    32'h2B0000, 32'h2D1004};
  int ro [4] = '{32'h810C4, 32'hC0C3F, 32'hD5A5A, 32'h261F40};
  logic [15:0] eb [4] = '{16'h0031, 16'h0032, 16'h61A9, 16'hFFFF};
  int lc [4] = '{0, 3, 4, 7};
  dcg_regs #(.SW_REV({5'd2, 5'd3, 6'd4}), .SERIAL(32'h5A5A_0C3F), .HFOV(16'h1F40)) dut_u (
    .clk_sys_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(q),
    .avs_waitrequest_o(wt), .avs_response_o(resp), .hw_trigger_i(trg),
    .frame_done_i(pl[0]), .frame_faulty_i(bad), .pixel_amplitude_i(amp),
    .capture_start_o(cap), .pixel_valid_o(pv), .ctrl_o(ctrl), .exposure_o(expo),
    .sense_i(sense), .boot_trial_i(pl[1]), .firmware_alive_i(pl[2]),
    .bootloader_active_i(bla), .boot_request_o(brq), .command_unlocked_o(unl));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (brq === 1'b1) sb <= 1'b1;
  // ====================
  // helpers
  function automatic logic [15:0] fit(logic [7:0] a, logic [15:0] d);
    case (a)
      8'h04: return d & 16'h0078;
      8'h05: return d < 16'h0032 ? 16'h0032 : (d > 16'h61A8 ? 16'h61A8 : d);
      8'h0B: return d & 16'h00FF;
      8'h19: return d & 16'h0988;
      default: return d;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    n = 0;
    @(posedge clk_sys_i);
    {adr, wr, rd, wd} <= {a, w, !w, 16'h0, d};
    do
      @(posedge clk_sys_i);
    while (wt !== 1'b0 && n++ < 50);
    if (wt !== 1'b0)
      chk(0, 1);
    {rq, rr} = {q, resp};
    {wr, rd} <= 2'b00;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    pl[k] <= 1'b1;
    @(posedge clk_sys_i);
    pl[k] <= 1'b0;
  endtask
  task automatic waitcap();
    n = 0;
    while (cap !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n > 95 && n < 110, 1);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ====================
  // tests
  initial
  begin
    void'($urandom(32'h332C));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (rv[i])
    begin
      m[rv[i] >> 16] = rv[i] & 32'hFFFF;
      bus(0, 8'(rv[i] >> 16), 0);
      chk(rq, m[rv[i] >> 16]);
    end
    chk(ctrl.video_mode, 1);
    $display("test reset values done");
    // primary control skipped: random bits would raise a boot request
    for (int i = 1; i < 15; i++)
    begin
      v = 16'($urandom);
      m[rv[i] >> 16] = fit(8'(rv[i] >> 16), v);
      bus(1, 8'(rv[i] >> 16), v);
      bus(0, 8'(rv[i] >> 16), 0);
      chk(rq, m[rv[i] >> 16]);
    end
    repeat (2) @(posedge clk_sys_i);
    chk(ctrl.lens_angle, m[11] & 255);
    // lane 0 only: upper byte must keep its value
    be <= 4'h1;
    bus(1, 8'h24, 16'hABCD);
    be <= 4'h3;
    m[36] = (m[36] & 32'hFF00) | 32'hCD;
    bus(0, 8'h24, 0);
    chk(rq, m[36]);
    foreach (eb[i])
    begin
      bus(1, 8'h05, eb[i]);
      bus(0, 8'h05, 0);
      chk({rq[15:0], expo}, {2{fit(8'h05, eb[i])}});
    end
    foreach (lc[i])
    begin
      bus(1, 8'h04, 16'(lc[i] << 3));
      repeat (2) @(posedge clk_sys_i);
      chk(ctrl.layout, lc[i]);
    end
    bus(1, 8'h19, 16'hFFFF);
    repeat (2) @(posedge clk_sys_i);
    chk({ctrl.auto_exposure, ctrl.segment_extremes}, 3);
    chk({ctrl.status_led_off, ctrl.median_min}, 3);
    $display("test writable registers done");
    foreach (ro[i])
    begin
      bus(1, 8'(ro[i] >> 16), 16'hFFFF);
      bus(0, 8'(ro[i] >> 16), 0);
      chk(rq, ro[i] & 32'hFFFF);
      chk(rr, 0);
    end
    bus(0, 8'h02, 0);
    chk(rr, 3);
    chk(rq, 0);
    bus(1, 8'h22, 16'h4877);
    repeat (2) @(posedge clk_sys_i);
    chk(unl, 1);
    bus(1, 8'h22, 16'h4876);
    repeat (2) @(posedge clk_sys_i);
    chk(unl, 0);
    v = 16'($urandom) | 16'h0001;
    bus(1, 8'h10, v);
    amp <= v;
    repeat (3) @(posedge clk_sys_i);
    chk(pv, 1);
    amp <= v - 16'h0001;
    repeat (3) @(posedge clk_sys_i);
    chk(pv, 0);
    $display("test read-only, key and threshold done");
    // ends the video frame begun after reset
    bus(1, 8'h01, 0);
    pulse(0);
    chk(ctrl.video_mode, 0);
    bus(1, 8'h01, 16'h0040);
    bus(0, 8'h03, 0);
    chk(rq, 0);
    bus(1, 8'h2B, 16'h0002);
    bus(1, 8'h01, 16'h0010);
    waitcap();
    pulse(0);
    bus(0, 8'h03, 0);
    chk(rq, 16'h0002);
    {trg, bad} <= 2'b11;
    waitcap();
    // 240 us of processing gives two whole 100 us units
    repeat (12000) @(posedge clk_sys_i);
    pulse(0);
    bus(0, 8'h03, 0);
    chk(rq, 16'h1002);
    bus(0, 8'h0E, 0);
    chk(rq, 3);
    bus(0, 8'h1A, 0);
    chk(rq, 2);
    $display("test capture done");
    v = 16'($urandom);
    {sense, bla, trg, bad} <= {5'b11011, 16'h0BB8, v, 3'b100};
    bus(1, 8'h01, 16'h0040);
    bus(0, 8'h03, 0);
    chk(rq, 16'h006D);
    bus(0, 8'h1B, 0);
    chk(rq, 16'hFFFF);
    bus(0, 8'h1C, 0);
    chk(rq, v);
    bus(1, 8'h01, 16'h0100);
    repeat (3) @(posedge clk_sys_i);
    chk(sb, 1);
    repeat (9) pulse(1);
    bus(0, 8'h2C, 0);
    chk(rq[15:13], 7);
    pulse(2);
    bus(0, 8'h2C, 0);
    chk(rq[15:13], 0);
    $display("test status and boot done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(0, 8'h05, 0);
    chk({rq[15:0], expo}, {2{16'h05DC}});
    $display("test reset in run done");
    conclude();
  end
  initial
  begin
    #400us;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
